// file: dcas_pkg.sv
// Shared constants for the level-one data cache access scheduler.
package dcas_pkg;
   localparam int ADDR_W          = 40;
   localparam int LINE_BYTES      = 64;
   localparam int LINE_OFF_W      = 6;
   localparam int NUM_BANKS       = 8;
   localparam int BANK_BYTES      = 16;
   localparam int BANK_LSB        = 4;
   localparam int BANK_W          = 3;
   localparam int INDEX_LSB       = 7;
   localparam int MAX_OUTSTANDING = 8;
   localparam int SLOT_W          = 3;
   localparam int ST_SIZE_W       = 4;
endpackage

// file: dcas_miss_table.sv
// Outstanding line request table with merging and fill release.
`timescale 1ns/1ns
module dcas_miss_table #(
   parameter int LINE_W = dcas_pkg::ADDR_W - dcas_pkg::LINE_OFF_W,
   parameter int DEPTH  = dcas_pkg::MAX_OUTSTANDING,
   parameter int SLOT_W = dcas_pkg::SLOT_W
) (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic              req_valid,
   input  wire logic [LINE_W-1:0] req_line,
   input  wire logic              req_modify,
   output logic                   req_ready,
   output logic                   req_merged,
   output logic                   issue_valid,
   output logic [LINE_W-1:0]      issue_line,
   output logic [SLOT_W-1:0]      issue_slot,
   output logic                   issue_modify,
   input  wire logic              fill_valid,
   input  wire logic [SLOT_W-1:0] fill_slot,
   output logic                   inst_valid,
   output logic [LINE_W-1:0]      inst_line,
   output logic                   inst_modified
);
   logic [DEPTH-1:0]  valid_reg, valid_next, mod_reg, mod_next, match;
   logic [LINE_W-1:0] line_reg [DEPTH];
   logic [LINE_W-1:0] line_next [DEPTH];
   logic              hit, free_found;
   logic [SLOT_W-1:0] hit_idx, free_idx;
   logic              issue_valid_next, issue_modify_next, inst_valid_next, inst_modified_next;
   logic [LINE_W-1:0] issue_line_next, inst_line_next;
   logic [SLOT_W-1:0] issue_slot_next;

   // An entry that is being filled this cycle no longer takes merges.
   genvar g;
   generate
      for (g = 0; g < DEPTH; g++)
      begin : g_match
         assign match[g] = valid_reg[g] && (line_reg[g] == req_line) &&
                           !(fill_valid && (fill_slot == SLOT_W'(g)));
      end
   endgenerate

   always_comb
   begin
      valid_next         = valid_reg;
      mod_next           = mod_reg;
      line_next          = line_reg;
      issue_valid_next   = 1'b0;
      issue_line_next    = issue_line;
      issue_slot_next    = issue_slot;
      issue_modify_next  = issue_modify;
      inst_valid_next    = 1'b0;
      inst_line_next     = inst_line;
      inst_modified_next = inst_modified;
      hit        = 1'b0;
      hit_idx    = '0;
      free_found = 1'b0;
      free_idx   = '0;
      for (int i = 0; i < DEPTH; i++)
      begin
         if (match[i])
         begin
            hit     = 1'b1;
            hit_idx = SLOT_W'(i);
         end
         if (!valid_reg[i] && !free_found)
         begin
            free_found = 1'b1;
            free_idx   = SLOT_W'(i);
         end
      end
      req_ready  = hit || free_found;
      req_merged = req_valid && hit;
      if (fill_valid && valid_reg[fill_slot])
      begin
         valid_next[fill_slot] = 1'b0;
         inst_valid_next       = 1'b1;
         inst_line_next        = line_reg[fill_slot];
         inst_modified_next    = mod_reg[fill_slot];
      end
      if (req_valid && hit)
      begin
         mod_next[hit_idx] = mod_reg[hit_idx] | req_modify;
      end
      else if (req_valid && free_found)
      begin
         valid_next[free_idx] = 1'b1;
         mod_next[free_idx]   = req_modify;
         line_next[free_idx]  = req_line;
         issue_valid_next     = 1'b1;
         issue_line_next      = req_line;
         issue_slot_next      = free_idx;
         issue_modify_next    = req_modify;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         valid_reg     <= '0;
         mod_reg       <= '0;
         issue_valid   <= 1'b0;
         issue_line    <= '0;
         issue_slot    <= '0;
         issue_modify  <= 1'b0;
         inst_valid    <= 1'b0;
         inst_line     <= '0;
         inst_modified <= 1'b0;
         for (int i = 0; i < DEPTH; i++)
         begin
            line_reg[i] <= '0;
         end
      end
      else
      begin
         valid_reg     <= valid_next;
         mod_reg       <= mod_next;
         line_reg      <= line_next;
         issue_valid   <= issue_valid_next;
         issue_line    <= issue_line_next;
         issue_slot    <= issue_slot_next;
         issue_modify  <= issue_modify_next;
         inst_valid    <= inst_valid_next;
         inst_line     <= inst_line_next;
         inst_modified <= inst_modified_next;
      end
   end

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   slot_limit_a: assert property (issue_valid |-> !$past(&valid_reg))
      else $error("New line request issued with every slot busy.");
   full_hold_a: assert property (req_valid && &valid_reg && !hit && !fill_valid |-> !req_ready ##1 !issue_valid)
      else $error("New line request taken with every slot busy.");
   merge_once_a: assert property (req_valid && hit |=> !issue_valid && $countones(valid_reg) <= $past($countones(valid_reg)))
      else $error("Request to an outstanding line took a new slot.");
   fill_modified_a: assert property (fill_valid && valid_reg[fill_slot] && mod_reg[fill_slot] |=> inst_valid && inst_modified)
      else $error("Write-intent line not installed modified.");
   cover_merge_c: cover property (req_valid && hit);
   cover_full_c: cover property (&valid_reg && req_valid && !req_ready);
endmodule

// file: dcas_scheduler.sv
// Load pairing, line request gating and write combining for the data cache.
`timescale 1ns/1ns
module dcas_scheduler #(
   parameter int ADDR_W = dcas_pkg::ADDR_W,
   parameter int DEPTH  = dcas_pkg::MAX_OUTSTANDING
) (
   input  wire logic                                  clk,
   input  wire logic                                  rst,
   input  wire logic                                  ld0_valid,
   input  wire logic [ADDR_W-1:0]                     ld0_addr,
   input  wire logic                                  ld1_valid,
   input  wire logic [ADDR_W-1:0]                     ld1_addr,
   output logic                                       ld_ready,
   output logic                                       done0_valid,
   output logic [ADDR_W-1:0]                          done0_addr,
   output logic                                       done1_valid,
   output logic [ADDR_W-1:0]                          done1_addr,
   input  wire logic                                  rq_valid,
   input  wire logic [ADDR_W-1:0]                     rq_addr,
   input  wire logic                                  rq_prefetch,
   input  wire logic                                  rq_modify,
   output logic                                       rq_ready,
   output logic                                       mem_req_valid,
   output logic [ADDR_W-dcas_pkg::LINE_OFF_W-1:0]     mem_req_line,
   output logic [dcas_pkg::SLOT_W-1:0]                mem_req_slot,
   output logic                                       mem_req_modify,
   input  wire logic                                  fill_valid,
   input  wire logic [dcas_pkg::SLOT_W-1:0]           fill_slot,
   output logic                                       inst_valid,
   output logic [ADDR_W-dcas_pkg::LINE_OFF_W-1:0]     inst_line,
   output logic                                       inst_modified,
   input  wire logic                                  st_valid,
   input  wire logic [ADDR_W-1:0]                     st_addr,
   input  wire logic [dcas_pkg::ST_SIZE_W-1:0]        st_size,
   output logic                                       st_ready,
   input  wire logic                                  wc_flush,
   output logic                                       wc_out_valid,
   output logic [ADDR_W-dcas_pkg::LINE_OFF_W-1:0]     wc_out_line,
   output logic [dcas_pkg::LINE_BYTES-1:0]            wc_out_mask,
   input  wire logic                                  wc_out_ready
);
   localparam int LINE_W = ADDR_W - dcas_pkg::LINE_OFF_W;

   typedef enum logic [0:0] {DCAS_LS_PAIR, DCAS_LS_DEFER} dcas_ld_state_t;

   // Bank and index fields; a conflict needs the same bank and a different index.
   function automatic logic dcas_bank_conflict(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
      return (a[dcas_pkg::BANK_LSB +: dcas_pkg::BANK_W] == b[dcas_pkg::BANK_LSB +: dcas_pkg::BANK_W]) &&
             (a[ADDR_W-1:dcas_pkg::INDEX_LSB] != b[ADDR_W-1:dcas_pkg::INDEX_LSB]);
   endfunction

   // -----------------------------------------------------------------
   // Load pairing
   // -----------------------------------------------------------------
   dcas_ld_state_t    state_reg, state_next;
   logic [ADDR_W-1:0] defer_addr_reg, defer_addr_next;
   logic              done0_valid_next, done1_valid_next, pair_conflict;
   logic [ADDR_W-1:0] done0_addr_next, done1_addr_next;

   always_comb
   begin
      state_next       = state_reg;
      defer_addr_next  = defer_addr_reg;
      done0_valid_next = 1'b0;
      done1_valid_next = 1'b0;
      done0_addr_next  = done0_addr;
      done1_addr_next  = done1_addr;
      pair_conflict    = ld0_valid && ld1_valid && dcas_bank_conflict(ld0_addr, ld1_addr);
      ld_ready         = (state_reg == DCAS_LS_PAIR);
      case (state_reg)
         DCAS_LS_PAIR:
         begin
            if (ld0_valid)
            begin
               done0_valid_next = 1'b1;
               done0_addr_next  = ld0_addr;
               if (ld1_valid && pair_conflict)
               begin
                  defer_addr_next = ld1_addr;
                  state_next      = DCAS_LS_DEFER;
               end
               else if (ld1_valid)
               begin
                  done1_valid_next = 1'b1;
                  done1_addr_next  = ld1_addr;
               end
            end
         end
         DCAS_LS_DEFER:
         begin
            done0_valid_next = 1'b1;
            done0_addr_next  = defer_addr_reg;
            state_next       = DCAS_LS_PAIR;
         end
         default:
         begin
            state_next = DCAS_LS_PAIR;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_reg      <= DCAS_LS_PAIR;
         defer_addr_reg <= '0;
         done0_valid    <= 1'b0;
         done1_valid    <= 1'b0;
         done0_addr     <= '0;
         done1_addr     <= '0;
      end
      else
      begin
         state_reg      <= state_next;
         defer_addr_reg <= defer_addr_next;
         done0_valid    <= done0_valid_next;
         done1_valid    <= done1_valid_next;
         done0_addr     <= done0_addr_next;
         done1_addr     <= done1_addr_next;
      end
   end

   // -----------------------------------------------------------------
   // Write combining
   // -----------------------------------------------------------------
   logic                           wc_open_reg, wc_open_next, wc_close_reg, wc_close_next;
   logic [LINE_W-1:0]              wc_line_reg, wc_line_next;
   logic [dcas_pkg::LINE_BYTES-1:0] wc_mask_reg, wc_mask_next, st_mask;
   logic [2*dcas_pkg::LINE_BYTES-1:0] st_wide;
   logic                           st_same_line;

   always_comb
   begin
      wc_open_next  = wc_open_reg;
      wc_close_next = wc_close_reg;
      wc_line_next  = wc_line_reg;
      wc_mask_next  = wc_mask_reg;
      // Bytes that spill past the line end are dropped from the mask.
      st_wide       = ((128'h1 << ({1'b0, st_size} + 5'h01)) - 128'h1) << st_addr[dcas_pkg::LINE_OFF_W-1:0];
      st_mask       = st_wide[dcas_pkg::LINE_BYTES-1:0];
      st_same_line  = wc_open_reg && (st_addr[ADDR_W-1:dcas_pkg::LINE_OFF_W] == wc_line_reg);
      st_ready      = !wc_close_reg && (!wc_open_reg || st_same_line);
      if (wc_close_reg)
      begin
         if (wc_out_ready)
         begin
            wc_close_next = 1'b0;
            wc_open_next  = 1'b0;
            wc_mask_next  = '0;
         end
      end
      else if (st_valid && st_same_line)
      begin
         wc_mask_next = wc_mask_reg | st_mask;
      end
      else if (st_valid && !wc_open_reg)
      begin
         wc_open_next = 1'b1;
         wc_line_next = st_addr[ADDR_W-1:dcas_pkg::LINE_OFF_W];
         wc_mask_next = st_mask;
      end
      else if (wc_open_reg && (st_valid || wc_flush))
      begin
         wc_close_next = 1'b1;
      end
      wc_out_valid = wc_close_reg;
      wc_out_line  = wc_line_reg;
      wc_out_mask  = wc_mask_reg;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         wc_open_reg  <= 1'b0;
         wc_close_reg <= 1'b0;
         wc_line_reg  <= '0;
         wc_mask_reg  <= '0;
      end
      else
      begin
         wc_open_reg  <= wc_open_next;
         wc_close_reg <= wc_close_next;
         wc_line_reg  <= wc_line_next;
         wc_mask_reg  <= wc_mask_next;
      end
   end

   // -----------------------------------------------------------------
   // Line requests
   // -----------------------------------------------------------------
   logic pf_block, tbl_ready;

   assign pf_block = rq_prefetch && wc_open_reg &&
                     (rq_addr[ADDR_W-1:dcas_pkg::LINE_OFF_W] == wc_line_reg);
   assign rq_ready = tbl_ready && !pf_block;

   dcas_miss_table #(
      .LINE_W (LINE_W),
      .DEPTH  (DEPTH),
      .SLOT_W (dcas_pkg::SLOT_W)
   ) u_table (
      .clk           (clk),
      .rst           (rst),
      .req_valid     (rq_valid && !pf_block),
      .req_line      (rq_addr[ADDR_W-1:dcas_pkg::LINE_OFF_W]),
      .req_modify    (rq_modify),
      .req_ready     (tbl_ready),
      .req_merged    (),
      .issue_valid   (mem_req_valid),
      .issue_line    (mem_req_line),
      .issue_slot    (mem_req_slot),
      .issue_modify  (mem_req_modify),
      .fill_valid    (fill_valid),
      .fill_slot     (fill_slot),
      .inst_valid    (inst_valid),
      .inst_line     (inst_line),
      .inst_modified (inst_modified)
   );

   // -----------------------------------------------------------------
   // Checks
   // -----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   pair_two_a: assert property (ld_ready && ld0_valid && ld1_valid && !pair_conflict |=> done0_valid && done1_valid)
      else $error("Conflict-free pair not served in one cycle.");
   conflict_split_a: assert property (ld_ready && ld0_valid && ld1_valid && pair_conflict |=>
      done0_valid && !done1_valid && done0_addr == $past(ld0_addr) ##1
      done0_valid && !done1_valid && done0_addr == $past(ld1_addr, 2) && ld_ready)
      else $error("Conflicting pair not split older first.");
   in_order_a: assert property (done1_valid |-> done0_valid && done0_addr == $past(ld0_addr) && done1_addr == $past(ld1_addr))
      else $error("Younger load completed without the older one.");
   conflict_rule_a: assert property (ld0_valid && ld1_valid &&
      ld0_addr[6:4] == ld1_addr[6:4] && ld0_addr[ADDR_W-1:7] == ld1_addr[ADDR_W-1:7] |-> !pair_conflict)
      else $error("Same bank and index flagged as conflict.");
   pf_stall_a: assert property (rq_valid && rq_prefetch && wc_open_reg &&
      rq_addr[ADDR_W-1:6] == wc_line_reg |-> !rq_ready)
      else $error("Prefetch taken against an uncommitted store.");
   wc_merge_a: assert property (st_valid && st_ready && wc_open_reg |=> wc_mask_reg == ($past(wc_mask_reg) | $past(st_mask)))
      else $error("Store in the open line not combined.");
   line_track_a: assert property (mem_req_valid |-> mem_req_line == $past(rq_addr[ADDR_W-1:6]))
      else $error("Issued line does not match request address.");
   write_intent_a: assert property (rq_valid && rq_ready && rq_modify |=> !mem_req_valid || mem_req_modify)
      else $error("Write-intent request issued without write intent.");
   cover_pair_c: cover property (done1_valid);
   cover_split_c: cover property (state_reg == DCAS_LS_DEFER);
   cover_pf_block_c: cover property (rq_valid && pf_block);
endmodule

// file: dcas_mem_model.sv
// Behavioural memory fill side that answers line requests in issue order.
`timescale 1ns/1ns
module dcas_mem_model #(
   parameter int DELAY = 3
) (
   input  wire logic                        clk,
   input  wire logic                        rst,
   input  wire logic                        fill_en,
   input  wire logic                        mem_req_valid,
   input  wire logic [dcas_pkg::SLOT_W-1:0] mem_req_slot,
   output logic                             fill_valid,
   output logic [dcas_pkg::SLOT_W-1:0]      fill_slot
);
   logic [dcas_pkg::SLOT_W-1:0] pend_q[$];
   int                          wait_cnt;
   initial
   begin
      fill_valid = 1'b0;
      fill_slot  = 3'h0;
      wait_cnt   = 0;
   end
   always @(posedge clk)
      if (rst) pend_q.delete();
      else if (mem_req_valid) pend_q.push_back(mem_req_slot);
   // The slot lines toggle while idle so a stale value is never mistaken for a fill.
   always @(negedge clk)
      if (!rst && fill_en && pend_q.size() > 0 && wait_cnt >= DELAY)
      begin
         fill_valid <= 1'b1;
         fill_slot  <= pend_q.pop_front();
         wait_cnt   <= 0;
      end
      else
      begin
         fill_valid <= 1'b0;
         fill_slot  <= ~fill_slot;
         wait_cnt   <= (fill_en && pend_q.size() > 0) ? wait_cnt + 1 : 0;
      end
endmodule

// file: l1_data_cache_access_scheduler_tb.sv
// Self-checking testbench for the data cache access scheduler.
`timescale 1ns/1ns
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("BAD %s expected %h seen %h", nm, exp, got); end end
module l1_data_cache_access_scheduler_tb;
   logic        clk, rst, ld0_valid, ld1_valid, ld_ready, done0_valid, done1_valid, rq_valid, rq_prefetch;
   logic        rq_modify, rq_ready, mem_req_valid, mem_req_modify, fill_valid, inst_valid, inst_modified;
   logic        st_valid, st_ready, wc_flush, wc_out_valid, wc_out_ready, fill_en;
   logic [39:0] ld0_addr, ld1_addr, done0_addr, done1_addr, rq_addr, st_addr;
   logic [33:0] mem_req_line, inst_line, wc_out_line;
   logic [2:0]  mem_req_slot, fill_slot;
   logic [3:0]  st_size;
   logic [63:0] wc_out_mask;
   logic [33:0] inst_q[$];
   logic        mod_q[$];
   int          error_cnt, checks, req_cnt;

   dcas_scheduler dut (.clk(clk), .rst(rst), .ld0_valid(ld0_valid), .ld0_addr(ld0_addr), .ld1_valid(ld1_valid),
      .ld1_addr(ld1_addr), .ld_ready(ld_ready), .done0_valid(done0_valid), .done0_addr(done0_addr),
      .done1_valid(done1_valid), .done1_addr(done1_addr), .rq_valid(rq_valid), .rq_addr(rq_addr),
      .rq_prefetch(rq_prefetch), .rq_modify(rq_modify), .rq_ready(rq_ready), .mem_req_valid(mem_req_valid),
      .mem_req_line(mem_req_line), .mem_req_slot(mem_req_slot), .mem_req_modify(mem_req_modify),
      .fill_valid(fill_valid), .fill_slot(fill_slot), .inst_valid(inst_valid), .inst_line(inst_line),
      .inst_modified(inst_modified), .st_valid(st_valid), .st_addr(st_addr), .st_size(st_size),
      .st_ready(st_ready), .wc_flush(wc_flush), .wc_out_valid(wc_out_valid), .wc_out_line(wc_out_line),
      .wc_out_mask(wc_out_mask), .wc_out_ready(wc_out_ready));
   dcas_mem_model mem (.clk(clk), .rst(rst), .fill_en(fill_en), .mem_req_valid(mem_req_valid),
      .mem_req_slot(mem_req_slot), .fill_valid(fill_valid), .fill_slot(fill_slot));

   initial clk = 1'b0;
   always #10 clk = ~clk;
   always @(posedge clk)
      if (!rst && inst_valid)
      begin
         inst_q.push_back(inst_line);
         mod_q.push_back(inst_modified);
      end
   always @(posedge clk)
      if (!rst && mem_req_valid) req_cnt++;

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic load_pair(input logic [39:0] a0, input logic [39:0] a1, input logic conf);
      @(negedge clk);
      {ld0_valid, ld1_valid, ld0_addr, ld1_addr} = {2'b11, a0, a1};
      `CHK("ld_ready", 1'b1, ld_ready)
      @(negedge clk);
      {ld0_valid, ld1_valid, ld0_addr, ld1_addr} = {2'b00, ~a0, ~a1};
      `CHK("done0_valid", 1'b1, done0_valid)
      `CHK("done0_addr", a0, done0_addr)
      `CHK("done1_valid", ~conf, done1_valid)
      `CHK("ld_ready", ~conf, ld_ready)
      if (!conf) `CHK("done1_addr", a1, done1_addr)
      else
      begin
         @(negedge clk);
         `CHK("done0_addr", a1, done0_addr)
         `CHK("done1_valid", 1'b0, done1_valid)
      end
   endtask

   task automatic line_req(input logic [39:0] a, input logic pf, input logic md, input logic nw);
      @(negedge clk);
      {rq_valid, rq_addr, rq_prefetch, rq_modify} = {1'b1, a, pf, md};
      #1;
      for (int i = 0; i < 40 && rq_ready !== 1'b1; i++) @(negedge clk);
      `CHK("rq_ready", 1'b1, rq_ready)
      @(negedge clk);
      {rq_valid, rq_addr} = {1'b0, ~a};
      `CHK("mem_req_valid", nw, mem_req_valid)
      if (nw) `CHK("mem_req_line", a[39:6], mem_req_line)
      if (nw) `CHK("mem_req_modify", md, mem_req_modify)
   endtask

   task automatic store(input logic [39:0] a, input logic [3:0] sz);
      @(negedge clk);
      {st_valid, st_addr, st_size} = {1'b1, a, sz};
      #1;
      for (int i = 0; i < 20 && st_ready !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      {st_valid, st_addr} = {1'b0, ~a};
   endtask

   task automatic wait_wc(input logic [33:0] ln, input logic [63:0] mk);
      for (int i = 0; i < 20 && wc_out_valid !== 1'b1; i++) @(negedge clk);
      `CHK("wc_out_line", ln, wc_out_line)
      `CHK("wc_out_mask", mk, wc_out_mask)
      @(negedge clk);
      `CHK("wc_out_valid", 1'b1, wc_out_valid)
      wc_out_ready = 1'b1;
      @(negedge clk);
      wc_out_ready = 1'b0;
   endtask

   task automatic test_lines;
      fill_en = 1'b0;
      for (int k = 0; k < 8; k++) line_req(40'h00_0001_0000 + 40'(k * 65), 1'b0, k == 0, 1'b1);
      line_req(40'h00_0001_00C9, 1'b1, 1'b1, 1'b0);
      @(negedge clk);
      {rq_valid, rq_addr, rq_prefetch, rq_modify} = {1'b1, 40'h00_0001_0200, 2'b00};
      #1;
      repeat (3)
      begin
         `CHK("rq_ready", 1'b0, rq_ready)
         @(negedge clk);
      end
      fill_en = 1'b1;
      line_req(40'h00_0001_0200, 1'b0, 1'b0, 1'b1);
      for (int i = 0; i < 200 && inst_q.size() < 9; i++) @(negedge clk);
      `CHK("installs", 9, inst_q.size())
      `CHK("requests", 9, req_cnt)
      for (int k = 0; k < 9 && k < inst_q.size(); k++)
      begin
         `CHK("inst_line", 34'h400 + 34'(k), inst_q[k])
         `CHK("inst_modified", k == 0 || k == 3, mod_q[k])
      end
   endtask

   task automatic test_wc;
      store(40'h00_0002_0002, 4'h3);
      store(40'h00_0002_003C, 4'h7);
      @(negedge clk);
      {rq_valid, rq_addr, rq_prefetch, rq_modify} = {1'b1, 40'h00_0002_0008, 2'b10};
      #1;
      `CHK("rq_ready", 1'b0, rq_ready)
      @(negedge clk);
      {rq_valid, rq_addr, st_valid, st_addr, st_size} = {1'b0, 40'hFF_FFFD_FFF7, 1'b1, 40'h00_0002_0150, 4'hF};
      @(negedge clk);
      `CHK("st_ready", 1'b0, st_ready)
      wait_wc(34'h800, 64'hF000_0000_0000_003C);
      for (int i = 0; i < 20 && st_ready !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
      {st_valid, st_addr} = {1'b0, 40'hFF_FFFD_FEAF};
      line_req(40'h00_0002_0008, 1'b1, 1'b0, 1'b1);
      wc_flush = 1'b1;
      @(negedge clk);
      wc_flush = 1'b0;
      wait_wc(34'h805, 64'h0000_0000_FFFF_0000);
      `CHK("wc_out_valid", 1'b0, wc_out_valid)
   endtask

   task end_sim;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {rst, ld0_valid, ld1_valid, rq_valid, rq_prefetch, rq_modify, st_valid, wc_flush, wc_out_ready} = 9'h100;
      {ld0_addr, ld1_addr, rq_addr, st_addr, st_size, fill_en} = '0;
      {error_cnt, checks, req_cnt} = '0;
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      load_pair(40'h00_0000_1000, 40'h00_0000_1008, 1'b0);
      load_pair(40'h00_0000_1000, 40'h00_0000_1010, 1'b0);
      load_pair(40'h00_0000_1000, 40'h00_0000_1040, 1'b0);
      load_pair(40'h00_0000_1070, 40'h00_0000_10F0, 1'b1);
      load_pair(40'h00_0000_1000, 40'h00_0000_1080, 1'b1);
      $display("load pairing test finished");
      test_lines;
      $display("line request test finished");
      test_wc;
      $display("write combining test finished");
      end_sim;
   end

   initial
   begin
      repeat (3000) @(posedge clk);
      error_cnt++;
      end_sim;
   end
endmodule
